// [hw/mae_pkg.sv]
// Purpose: Shared constants and types of the motion alarm event logic
// Assumes: sys_clk at 100 MHz, one system clock of the device per cycle
// Notes:   Times in ns or ms derive cycle counts; BW_CYC, IDLE_CYC, FR_CYC, RD_END_CYC and ADC_INT_CYC are set in cycles
package mae_pkg;
  localparam int CLK_NS       = 10;
  localparam int CLR_LOW_NS   = 100;
  localparam int CLR_LOW_CYC  = (CLR_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_SEC_MS  = 500;
  localparam int HALF_SEC_CYC = HALF_SEC_MS * 1000000 / CLK_NS;
  localparam int TH_NS        = 200;
  localparam int TH_CYC       = TH_NS / CLK_NS;
  localparam int BW_CYC       = 2;
  localparam int SMP_CYC      = TH_CYC + BW_CYC - 1;
  localparam int IDLE_CYC     = 16;
  localparam int FR_CYC       = 2;
  localparam int RD_END_CYC   = 4;
  localparam int RD_BIT_NS    = 1000;
  localparam int RD_BIT_CYC   = RD_BIT_NS / CLK_NS;
  localparam int ADC_INT_CYC  = 512;
  localparam int CFG_BITS     = 25;
  localparam int WIN_HALVES   = 4;
  localparam logic [7:0] A_STAT  = 8'h00;
  localparam logic [7:0] A_MASK  = 8'h04;
  localparam logic [7:0] A_CFG   = 8'h08;
  localparam logic [7:0] A_STATE = 8'h0c;
  localparam int ST_ALARM = 0;
  localparam int ST_CLR   = 1;
  localparam int ST_CFG   = 2;
  localparam int ST_RD    = 3;
  localparam int ST_W     = 4;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;

  typedef struct packed {
    logic [7:0] sens;
    logic [3:0] blind;
    logic [1:0] pulses;
    logic [1:0] window;
    logic       md_en;
    logic       int_src;
    logic [1:0] adc_src;
    logic       pir_off;
    logic [3:0] test;
  } mae_cfg_s;
  localparam mae_cfg_s CFG_RST = 25'h0000000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mae_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mae_apb_rsp_s;

  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_HOST  = 3'b010,
    RD_SHIFT = 3'b100
  } mae_rd_e;
endpackage

// [hw/mae_motion_alarm.sv]
// Purpose: Motion alarm event logic with serial setup and int/data line
// Assumes: ir_level/ir_valid come from logic on sys_clk; wire has pull-down
// Notes:   The device drives the int/data line high only, never low
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module mae_motion_alarm #(
  parameter int unsigned HALF_SEC_CYC = mae_pkg::HALF_SEC_CYC,
  parameter int          SIG_W        = 16
) (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    serial_in,
  input  wire logic                    intd_in,
  input  wire logic signed [SIG_W-1:0] ir_level,
  input  wire logic                    ir_valid,
  input  wire mae_pkg::mae_apb_req_s   apb_req,
  output logic                         intd_out,
  output logic                         intd_oe,
  output logic                         irq,
  output mae_pkg::mae_apb_rsp_s        apb_rsp
);
  // Synchronisers
  logic ser_s1, ser_s2, ser_d, int_s1, int_s2;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {ser_s1, ser_s2, ser_d, int_s1, int_s2} <= 5'h00;
    end else begin
      ser_s1 <= serial_in;
      ser_s2 <= ser_s1;
      ser_d  <= ser_s2;
      int_s1 <= intd_in;
      int_s2 <= int_s1;
    end
  end

  // Serial setup input
  logic [4:0]  low_cnt_reg, low_cnt_next, smp_reg, smp_next;
  logic [4:0]  nbit_reg, nbit_next;
  logic        armed_reg, armed_next, cfg_evt;
  logic [24:0] shift_reg, shift_next;
  mae_pkg::mae_cfg_s cfg_reg, cfg_next;
  always_comb begin
    low_cnt_next = ser_s2 ? 5'h00 : low_cnt_reg + 5'h01;
    if (!ser_s2 && low_cnt_reg == 5'(mae_pkg::IDLE_CYC + 1)) begin
      low_cnt_next = low_cnt_reg;
    end
    armed_next = armed_reg ||
      (!ser_s2 && low_cnt_reg == 5'(mae_pkg::IDLE_CYC - 1));
    smp_next   = smp_reg;
    shift_next = shift_reg;
    nbit_next  = nbit_reg;
    cfg_next   = cfg_reg;
    cfg_evt    = 1'b0;
    if (armed_reg && ser_s2 && !ser_d && smp_reg == 5'h00) begin
      smp_next = 5'h01;
    end else if (smp_reg == 5'(mae_pkg::SMP_CYC)) begin
      shift_next = {shift_reg[23:0], ser_s2};
      smp_next   = 5'h00;
      if (nbit_reg != 5'(mae_pkg::CFG_BITS)) begin
        nbit_next = nbit_reg + 5'h01;
      end
    end else if (smp_reg != 5'h00) begin
      smp_next = smp_reg + 5'h01;
    end
    if (!ser_s2 && low_cnt_reg == 5'(mae_pkg::IDLE_CYC) &&
        nbit_reg != 5'h00 && smp_reg == 5'h00) begin
      cfg_next  = shift_reg;
      nbit_next = 5'h00;
      cfg_evt   = 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      low_cnt_reg <= 5'h00;
      smp_reg     <= 5'h00;
      nbit_reg    <= 5'h00;
      armed_reg   <= 1'b0;
      shift_reg   <= 25'h0000000;
      cfg_reg     <= mae_pkg::CFG_RST;
    end else begin
      low_cnt_reg <= low_cnt_next;
      smp_reg     <= smp_next;
      nbit_reg    <= nbit_next;
      armed_reg   <= armed_next;
      shift_reg   <= shift_next;
      cfg_reg     <= cfg_next;
    end
  end

  // Motion detection, interrupt, blind time and readout
  logic signed [SIG_W-1:0] thr, nthr;
  logic        pos, neg, pulse, accept, det, clr_evt, rd_evt, alarm;
  logic        pos_q, neg_q, sgn_q, pend_reg, drive_reg;
  logic        pos_qn, neg_qn, sgn_qn, pend_next, drive_next;
  logic [2:0]  pcnt_reg, pcnt_next;
  logic [3:0]  blind_reg, blind_next, lo_reg, lo_next;
  logic [4:0]  win_reg, win_next, idx_reg, idx_next;
  logic [6:0]  rcnt_reg, rcnt_next;
  logic [8:0]  adc_reg;
  logic [31:0] tick_reg, tick_next;
  logic        tick;
  mae_pkg::mae_rd_e rd_reg, rd_next;
  always_comb begin
    thr  = SIG_W'(cfg_reg.sens);
    nthr = -thr;
    pos  = ir_level > thr;
    neg  = ir_level < nthr;
    pulse = ir_valid && ((pos && !pos_q) || (neg && !neg_q));
    pos_qn = ir_valid ? pos : pos_q;
    neg_qn = ir_valid ? neg : neg_q;
    det = cfg_reg.md_en && blind_reg == 4'h0 && !pend_reg &&
          rd_reg == mae_pkg::RD_IDLE;
    accept = det && pulse && (pcnt_reg == 3'h0 || neg != sgn_q);
    sgn_qn = accept ? neg : sgn_q;
    tick = tick_reg == HALF_SEC_CYC - 1;
    tick_next = tick ? 32'h0 : tick_reg + 32'h1;
    pcnt_next  = pcnt_reg;
    win_next   = win_reg;
    blind_next = blind_reg;
    alarm = 1'b0;
    if (tick && blind_reg != 4'h0) begin
      blind_next = blind_reg - 4'h1;
    end
    if (tick && win_reg != 5'h00) begin
      win_next = win_reg - 5'h01;
      if (win_reg == 5'h01) begin
        pcnt_next = 3'h0;
      end
    end
    if (accept) begin
      if (pcnt_reg == 3'h0) begin
        win_next  = 5'(({3'h0, cfg_reg.window} + 5'h01) *
                        mae_pkg::WIN_HALVES);
        tick_next = 32'h0;
      end
      pcnt_next = pcnt_reg + 3'h1;
      if (pcnt_reg == {1'b0, cfg_reg.pulses}) begin
        alarm     = 1'b1;
        pcnt_next = 3'h0;
        win_next  = 5'h00;
      end
    end
    if (cfg_reg.int_src) begin
      alarm = adc_reg == 9'(mae_pkg::ADC_INT_CYC - 1);
    end
    pend_next = pend_reg;
    rd_next   = rd_reg;
    rcnt_next = rcnt_reg;
    idx_next  = idx_reg;
    lo_next   = 4'h0;
    clr_evt   = 1'b0;
    rd_evt    = 1'b0;
    if (alarm && rd_reg == mae_pkg::RD_IDLE) begin
      pend_next = 1'b1;
    end
    if (pend_reg && !int_s2) begin
      lo_next = lo_reg + 4'h1;
      if (lo_reg == 4'(mae_pkg::CLR_LOW_CYC - 1)) begin
        pend_next  = 1'b0;
        clr_evt    = 1'b1;
        lo_next    = 4'h0;
        blind_next = cfg_reg.blind;
        tick_next  = 32'h0;
        pcnt_next  = 3'h0;
        win_next   = 5'h00;
      end
    end
    case (rd_reg)
      mae_pkg::RD_IDLE: begin
        rcnt_next = (int_s2 && !pend_reg) ? rcnt_reg + 7'h01 : 7'h00;
        if (int_s2 && !pend_reg && rcnt_reg == 7'(mae_pkg::FR_CYC)) begin
          rd_next = mae_pkg::RD_HOST;
          rd_evt  = 1'b1;
        end
      end
      mae_pkg::RD_HOST: begin
        rcnt_next = 7'h00;
        idx_next  = 5'(mae_pkg::CFG_BITS - 1);
        if (!int_s2) begin
          rd_next = mae_pkg::RD_SHIFT;
        end
      end
      mae_pkg::RD_SHIFT: begin
        rcnt_next = rcnt_reg + 7'h01;
        if (rcnt_reg == 7'(mae_pkg::RD_BIT_CYC - 1)) begin
          rcnt_next = 7'h00;
          idx_next  = idx_reg - 5'h01;
          if (idx_reg == 5'h00) begin
            rd_next = mae_pkg::RD_IDLE;
          end
        end
        if (drive_reg && !int_s2) begin
          lo_next = lo_reg + 4'h1;
          if (lo_reg == 4'(mae_pkg::RD_END_CYC - 1)) begin
            rd_next   = mae_pkg::RD_IDLE;
            rcnt_next = 7'h00;
          end
        end
      end
      default: rd_next = mae_pkg::RD_IDLE;
    endcase
    drive_next = pend_next ||
      (rd_next == mae_pkg::RD_SHIFT && cfg_reg[idx_next]);
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {pos_q, neg_q, sgn_q, pend_reg, drive_reg} <= 5'h00;
      pcnt_reg  <= 3'h0;
      blind_reg <= 4'h0;
      lo_reg    <= 4'h0;
      win_reg   <= 5'h00;
      idx_reg   <= 5'h00;
      rcnt_reg  <= 7'h00;
      adc_reg   <= 9'h000;
      tick_reg  <= 32'h0;
      rd_reg    <= mae_pkg::RD_IDLE;
    end else begin
      {pos_q, neg_q, sgn_q} <= {pos_qn, neg_qn, sgn_qn};
      pend_reg  <= pend_next;
      drive_reg <= drive_next;
      pcnt_reg  <= pcnt_next;
      blind_reg <= blind_next;
      lo_reg    <= lo_next;
      win_reg   <= win_next;
      idx_reg   <= idx_next;
      rcnt_reg  <= rcnt_next;
      adc_reg   <= adc_reg + 9'h001;
      tick_reg  <= tick_next;
      rd_reg    <= rd_next;
    end
  end
  assign intd_out = drive_reg;
  assign intd_oe  = drive_reg;

  // APB slave, status, mask and interrupt output
  logic [mae_pkg::ST_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        rdy_reg, rdy_next, err_reg, err_next, irq_reg, irq_next;
  logic        acc, wr, hit;
  always_comb begin
    acc = apb_req.psel && apb_req.penable;
    wr  = acc && rdy_reg && apb_req.pwrite;
    rdy_next   = acc && !rdy_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    hit = apb_req.paddr == mae_pkg::A_STAT || apb_req.paddr == mae_pkg::A_MASK
       || apb_req.paddr == mae_pkg::A_CFG || apb_req.paddr == mae_pkg::A_STATE;
    if (acc && !rdy_reg) begin
      err_next = !hit;
      case (apb_req.paddr)
        mae_pkg::A_STAT:  rdata_next = 32'(stat_reg);
        mae_pkg::A_MASK:  rdata_next = 32'(mask_reg);
        mae_pkg::A_CFG:   rdata_next = 32'(cfg_reg);
        mae_pkg::A_STATE: rdata_next = {20'h00000, rd_reg, pcnt_reg,
                                        blind_reg, armed_reg, pend_reg};
        default:          rdata_next = 32'h00000000;
      endcase
    end
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (wr && apb_req.paddr == mae_pkg::A_STAT) begin
      stat_next = stat_reg & ~apb_req.pwdata[mae_pkg::ST_W-1:0];
    end
    if (wr && apb_req.paddr == mae_pkg::A_MASK) begin
      mask_next = apb_req.pwdata[mae_pkg::ST_W-1:0];
    end
    stat_next = stat_next | {rd_evt, cfg_evt, clr_evt,
                             pend_next && !pend_reg};
    irq_next = |(stat_next & mask_next);
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stat_reg  <= '0;
      mask_reg  <= mae_pkg::MASK_RST;
      rdata_reg <= 32'h00000000;
      {rdy_reg, err_reg, irq_reg} <= 3'h0;
    end else begin
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      {rdy_reg, err_reg, irq_reg} <= {rdy_next, err_next, irq_next};
    end
  end
  assign apb_rsp = '{prdata: rdata_reg, pready: rdy_reg, pslverr: err_reg};
  assign irq = irq_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_THR: assert property (pulse |-> ir_level > thr || ir_level < nthr)
    else $error("Pulse without threshold crossing");
  AST_SIGN: assert property (accept && pcnt_reg != 3'h0 |-> neg != sgn_q)
    else $error("Pulse counted without sign change");
  AST_ALARM: assert property (accept && !cfg_reg.int_src &&
      pcnt_reg == {1'b0, cfg_reg.pulses} |=> pend_reg ##1 intd_oe)
    else $error("Alarm not raised after set pulse count");
  AST_BLIND: assert property (blind_reg != 4'h0 |-> !accept)
    else $error("Detection during blind time");
  AST_CLR: assert property ($fell(pend_reg) |-> !$past(int_s2) &&
      $past(lo_reg) == 4'(mae_pkg::CLR_LOW_CYC - 1))
    else $error("Interrupt cleared without long enough low");
  AST_CFG: assert property (cfg_reg != $past(cfg_reg) |->
      $past(nbit_reg) != 5'h00 &&
      $past(low_cnt_reg) == 5'(mae_pkg::IDLE_CYC))
    else $error("Setup changed outside serial latch");
  AST_DOUT: assert property (intd_oe |-> intd_out &&
      (pend_reg || rd_reg == mae_pkg::RD_SHIFT))
    else $error("Line driven outside interrupt or readout");
  AST_ARM: assert property (!armed_reg |-> smp_reg == 5'h00)
    else $error("Bit taken before serial input armed");
  AST_RDST: assert property ($rose(rd_reg == mae_pkg::RD_HOST) |->
      $past(int_s2, 1) && $past(int_s2, 2) && $past(int_s2, 3))
    else $error("Readout started on short high");
  AST_RDEND: assert property (rd_reg == mae_pkg::RD_SHIFT &&
      (drive_reg && !int_s2) [*4] |=> rd_reg == mae_pkg::RD_IDLE)
    else $error("Readout not ended by low line");
  AST_SYNC: assert property ($past(nrst) && $past(nrst, 2) |->
      int_s2 == $past(intd_in, 2))
    else $error("Line not sampled through two stages");
  COV_ALARM: cover property ($rose(pend_reg));
  COV_CLR: cover property (clr_evt ##1 blind_reg != 4'h0);
  COV_CFG: cover property (cfg_evt);
  COV_RD: cover property (rd_reg == mae_pkg::RD_SHIFT);
endmodule // mae_motion_alarm

// [verif/mae_host_model.sv]
// Purpose: Host controller model on the serial input and int/data wire
// Assumes: Tasks are called just after a rising edge of sys_clk
// Notes:   Wire has a pull-down; host low wins over device high
`timescale 1ns/1ps
module mae_host_model (
  input  wire logic sys_clk,
  input  wire logic intd_out,
  input  wire logic intd_oe,
  output logic      intd_in,
  output logic      serial_in
);
  logic host_drv;
  logic host_val;

  initial begin
    host_drv  = 1'b0;
    host_val  = 1'b0;
    serial_in = 1'b0;
  end

  // Released wire falls to the pull-down level
  assign intd_in = host_drv ? host_val : (intd_oe & intd_out);

  // Host forces the wire for n cycles
  task automatic drive(input logic v, input int n);
    host_drv <= 1'b1;
    host_val <= v;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic release_line();
    host_drv <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic ser(input logic v, input int n);
    serial_in <= v;
    repeat (n) @(posedge sys_clk);
  endtask

  // Arm low, then rise, high phase, bit value, then idle to latch
  task automatic send_frame(input logic [24:0] w);
    ser(1'b0, 20);
    for (int i = 24; i >= 0; i--) begin
      ser(1'b0, 4);
      ser(1'b1, 20);
      ser(w[i], 6);
    end
    ser(1'b0, 25);
  endtask
endmodule // mae_host_model

// [verif/mae_motion_alarm_tb_top.sv]
// Purpose: Self-checking bench of the motion alarm event logic
// Assumes: Half second shortened to 100 cycles
// Notes:   Host model drives serial input and int/data wire
`timescale 1ns/1ps
module mae_motion_alarm_tb_top;
  localparam int          HS      = 100;
  localparam logic [24:0] SETUP_W = {8'h90, 4'h1, 2'h1, 2'h0, 1'b1,
                                     1'b0, 2'h0, 1'b0, 4'h0};
  logic                  sys_clk;
  logic                  nrst;
  logic                  serial_in;
  logic                  intd_in;
  logic signed [15:0]    ir_level;
  logic                  ir_valid;
  mae_pkg::mae_apb_req_s apb_req;
  mae_pkg::mae_apb_rsp_s apb_rsp;
  logic                  intd_out;
  logic                  intd_oe;
  logic                  irq;
  logic [31:0]           rd;
  logic                  err;
  int                    n_mismatch;
  int                    tests_run;

  mae_motion_alarm #(.HALF_SEC_CYC(HS), .SIG_W(16)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .serial_in(serial_in),
    .intd_in(intd_in), .ir_level(ir_level), .ir_valid(ir_valid),
    .apb_req(apb_req), .intd_out(intd_out), .intd_oe(intd_oe),
    .irq(irq), .apb_rsp(apb_rsp));

  mae_host_model u_host (
    .sys_clk(sys_clk), .intd_out(intd_out), .intd_oe(intd_oe),
    .intd_in(intd_in), .serial_in(serial_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic ir(input logic signed [15:0] v, input int n);
    ir_level <= v;
    ir_valid <= 1'b1;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic two_pulses();
    ir(16'sd200, 4);
    ir(16'sd0, 4);
    ir(-16'sd200, 4);
    ir(16'sd0, 6);
  endtask

  task automatic t_reset();
    rdc(mae_pkg::A_STAT, 32'h0);
    rdc(mae_pkg::A_MASK, 32'h0);
    rdc(mae_pkg::A_CFG, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_setup();
    apb(1'b1, mae_pkg::A_MASK, 32'hf);
    u_host.send_frame(SETUP_W);
    rdc(mae_pkg::A_CFG, {7'h0, SETUP_W});
    rdc(mae_pkg::A_STAT, 32'h4);
    apb(1'b1, mae_pkg::A_STAT, 32'h4);
    rdc(mae_pkg::A_STAT, 32'h0);
    $display("test setup done");
  endtask

  task automatic t_alarm();
    ir(16'sh0090, 4);
    ir(16'sd0, 4);
    ir(-16'sh0090, 4);
    ir(16'sd0, 6);
    chk({31'h0, intd_oe}, 32'h0);
    ir(16'sd200, 4);
    ir(16'sd0, 4);
    ir(16'sd200, 4);
    ir(16'sd0, 6);
    chk({31'h0, intd_oe}, 32'h0);
    ir(-16'sd200, 4);
    ir(16'sd0, 6);
    chk({31'h0, intd_oe}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(mae_pkg::A_STAT, 32'h1);
    apb(1'b1, mae_pkg::A_MASK, 32'he);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, mae_pkg::A_MASK, 32'hf);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, mae_pkg::A_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test alarm done");
  endtask

  task automatic t_clear();
    u_host.drive(1'b0, 5);
    u_host.release_line();
    repeat (5) @(posedge sys_clk);
    chk({31'h0, intd_oe}, 32'h1);
    u_host.drive(1'b0, 12);
    u_host.release_line();
    repeat (3) @(posedge sys_clk);
    chk({31'h0, intd_oe}, 32'h0);
    rdc(mae_pkg::A_STAT, 32'h2);
    two_pulses();
    chk({31'h0, intd_oe}, 32'h0);
    repeat (200) @(posedge sys_clk);
    two_pulses();
    chk({31'h0, intd_oe}, 32'h1);
    u_host.drive(1'b0, 12);
    u_host.release_line();
    apb(1'b1, mae_pkg::A_STAT, 32'hf);
    $display("test clear done");
  endtask

  task automatic t_read();
    repeat (250) @(posedge sys_clk);
    u_host.drive(1'b1, 4);
    u_host.release_line();
    repeat (50) @(posedge sys_clk);
    chk({31'h0, intd_oe}, {31'h0, SETUP_W[24]});
    repeat (100) @(posedge sys_clk);
    chk({31'h0, intd_oe}, {31'h0, SETUP_W[23]});
    repeat (200) @(posedge sys_clk);
    chk({31'h0, intd_oe}, {31'h0, SETUP_W[21]});
    chk({31'h0, intd_out}, {31'h0, SETUP_W[21]});
    u_host.drive(1'b0, 6);
    u_host.release_line();
    repeat (3) @(posedge sys_clk);
    chk({31'h0, intd_oe}, 32'h0);
    apb(1'b0, mae_pkg::A_STAT, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    apb(1'b0, mae_pkg::A_STATE, 32'h0);
    chk({29'h0, rd[11:9]}, 32'h1);
    $display("test readout done");
  endtask

  task automatic t_adc();
    u_host.send_frame(SETUP_W | 25'h80);
    rdc(mae_pkg::A_CFG, {7'h0, SETUP_W | 25'h80});
    repeat (520) @(posedge sys_clk);
    chk({31'h0, intd_oe}, 32'h1);
    chk({31'h0, intd_out}, 32'h1);
    $display("test adc source done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    nrst       = 1'b0;
    ir_level   = 16'sd0;
    ir_valid   = 1'b0;
    apb_req    = '0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_setup();
    t_alarm();
    t_clear();
    t_read();
    t_adc();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule // mae_motion_alarm_tb_top
